// [design/mbcrc_engine.sv]
// Check-code engine for RTU frames: accumulate, emit and compare.
// Assumes a framer or parser giving one byte per valid with positions.
//
// Behaviour
// [RULE_01] Check value is always two bytes, sixteen bits.
// [RULE_02] Check applied only in RTU framing mode.
// [RULE_03] Range consumed one byte at a time in packet order.
// [RULE_04] Accumulator seeded all ones before first byte.
// [RULE_05] Byte xored into low eight accumulator bits.
// [RULE_06] Shift right; xor polynomial a001 when bit out was one.
// [RULE_07] Exactly eight conditional shifts per byte.
// [RULE_08] After all bytes, accumulator is the check value.
// [RULE_09] Low byte of check value first, high byte second.
// [RULE_10] Covered range selected by start and end positions.
// [RULE_11] Unchecked receive elements accepted without comparison.
// [RULE_12] Receive mismatch flags error; accumulator cleared per packet.
`timescale 1ns/1ps
`include "mbcrc_cfg.svh"
module mbcrc_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration
  input wire mbcrc_pkg::mbcrc_frame_t frame_mode,
  input wire mbcrc_pkg::mbcrc_pos_t range_start,
  input wire mbcrc_pkg::mbcrc_pos_t range_end,
  // Byte stream
  input wire logic pkt_start,
  input wire logic byte_valid,
  input wire mbcrc_pkg::mbcrc_byte_t byte_data,
  input wire mbcrc_pkg::mbcrc_pos_t byte_pos,
  input wire logic byte_unchecked,
  input wire logic range_done,
  output logic byte_ready,
  // Receive check bytes
  input wire logic chk_valid,
  input wire mbcrc_pkg::mbcrc_byte_t chk_byte,
  // Results
  output mbcrc_pkg::mbcrc_word_t crc_value,
  output logic crc_done,
  output mbcrc_pkg::mbcrc_byte_t tx_lo,
  output mbcrc_pkg::mbcrc_byte_t tx_hi,
  output logic chk_done,
  output logic chk_error
);
  import mbcrc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  mbcrc_state_t state_r, state_nxt;
  mbcrc_word_t acc_r, acc_nxt;
  logic [3:0] shift_cnt_r, shift_cnt_nxt;
  mbcrc_byte_t rx_lo_r, rx_lo_nxt;
  logic byte_ready_r;
  mbcrc_word_t crc_value_r;
  logic crc_done_r, chk_done_r, chk_error_r;
  logic range_done_pend_r, range_done_pend_nxt;

  mbcrc_step_if st ();
  mbcrc_step u_step (
    .st(st)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire rtu_mode = (frame_mode == MBCRC_FRAME_RTU); // see [RULE_02]
  // Range check by position; the end may sit short of the last element
  wire in_range = (byte_pos >= range_start) && (byte_pos <= range_end); // see [RULE_10]
  // Unchecked elements take any contents and leave the sum alone
  wire take_byte = (state_r == MBCRC_IDLE) && byte_valid && rtu_mode
                   && in_range && !byte_unchecked; // see [RULE_11]
  wire shifting = (state_r == MBCRC_SHIFT);
  wire last_shift = shifting && (shift_cnt_r == (`MBCRC_SHIFTS - 4'h1)); // see [RULE_07]
  wire [15:0] merged = {acc_r[15:8], acc_r[7:0] ^ byte_data}; // see [RULE_05]
  // A range end seen mid-shift waits here until the byte is done
  wire done_pend = range_done_pend_r | (range_done & rtu_mode);
  wire finish_now = done_pend && (state_nxt == MBCRC_IDLE) && !pkt_start;
  // Pending end clears once it finishes or a new packet starts
  assign range_done_pend_nxt = done_pend && !finish_now && !pkt_start;

  assign st.acc_in = acc_r;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    shift_cnt_nxt = shift_cnt_r;
    rx_lo_nxt = rx_lo_r;
    case (state_r)
      MBCRC_IDLE: begin
        if (take_byte) begin
          acc_nxt = merged; // see [RULE_03]
          shift_cnt_nxt = 4'h0;
          state_nxt = MBCRC_SHIFT;
        end else if (chk_valid && rtu_mode) begin
          rx_lo_nxt = chk_byte; // see [RULE_09]
          state_nxt = MBCRC_CHK_HI;
        end
      end
      MBCRC_SHIFT: begin
        acc_nxt = st.acc_out; // see [RULE_06]
        shift_cnt_nxt = shift_cnt_r + 4'h1;
        if (last_shift) begin
          state_nxt = MBCRC_IDLE; // see [RULE_08]
        end
      end
      MBCRC_CHK_HI: begin
        if (chk_valid) begin
          state_nxt = MBCRC_IDLE;
        end
      end
      MBCRC_CHK_LO: begin
        state_nxt = MBCRC_IDLE;
      end
      default: begin
        state_nxt = MBCRC_IDLE;
      end
    endcase
    // New packet wins over everything and reseeds
    if (pkt_start) begin
      acc_nxt = `MBCRC_SEED; // see [RULE_04] [RULE_12]
      shift_cnt_nxt = 4'h0;
      state_nxt = MBCRC_IDLE;
    end
  end

  wire chk_hi_take = (state_r == MBCRC_CHK_HI) && chk_valid && !pkt_start;
  // Compare in low-then-high order against the finished value
  wire chk_mismatch = ({chk_byte, rx_lo_r} != crc_value_r); // see [RULE_12]

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= MBCRC_IDLE;
      acc_r <= `MBCRC_SEED; // see [RULE_04]
      shift_cnt_r <= 4'h0;
      rx_lo_r <= `MBCRC_BYTE_RST;
      range_done_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      shift_cnt_r <= shift_cnt_nxt;
      rx_lo_r <= rx_lo_nxt;
      range_done_pend_r <= range_done_pend_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_value_r <= `MBCRC_SEED;
      crc_done_r <= 1'b0;
    end else begin
      crc_done_r <= finish_now;
      if (pkt_start) begin
        crc_value_r <= `MBCRC_SEED;
      end else if (finish_now) begin
        crc_value_r <= acc_nxt; // see [RULE_01] [RULE_08]
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chk_done_r <= 1'b0;
      chk_error_r <= 1'b0;
    end else begin
      chk_done_r <= chk_hi_take;
      if (pkt_start) begin
        chk_error_r <= 1'b0;
      end else if (chk_hi_take) begin
        chk_error_r <= chk_mismatch; // see [RULE_12]
      end
    end
  end

  // Ready only when idle, so a byte is never merged mid-shift
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byte_ready_r <= 1'b0;
    end else begin
      byte_ready_r <= (state_nxt == MBCRC_IDLE); // see [RULE_07]
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign byte_ready = byte_ready_r;
  assign crc_value = crc_value_r;
  assign crc_done = crc_done_r;
  assign tx_lo = crc_value_r[7:0]; // see [RULE_09]
  assign tx_hi = crc_value_r[15:8]; // see [RULE_09]
  assign chk_done = chk_done_r;
  assign chk_error = chk_error_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [3:0] run_cnt_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_cnt_r <= 4'h0;
    end else if (shifting && !pkt_start) begin
      run_cnt_r <= run_cnt_r + 4'h1;
    end else begin
      run_cnt_r <= 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_SEED_ON_START: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_04]
    pkt_start |=> (acc_r == `MBCRC_SEED))
    else $error("accumulator not seeded at packet start");
  AST_MERGE_LOW: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_05]
    take_byte && !pkt_start |=> (acc_r == {$past(acc_r[15:8]), $past(acc_r[7:0] ^ byte_data)}))
    else $error("byte not merged into low half");
  AST_STEP_POLY: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_06]
    shifting && !pkt_start && acc_r[0] |=> (acc_r == (($past(acc_r) >> 1) ^ `MBCRC_POLY)))
    else $error("polynomial step wrong");
  AST_EIGHT_SHIFTS: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_07]
    take_byte && !pkt_start |=> shifting [*8] ##1 (state_r == MBCRC_IDLE))
    else $error("byte did not take eight shifts");
  AST_RUN_BOUND: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_07]
    run_cnt_r <= 4'h8)
    else $error("shift run too long");
  AST_NOT_RTU: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_02]
    !rtu_mode && (state_r == MBCRC_IDLE) && !pkt_start |=> (state_r == MBCRC_IDLE))
    else $error("engine ran outside rtu mode");
  AST_UNCHECKED: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_11]
    (state_r == MBCRC_IDLE) && byte_valid && byte_unchecked && !chk_valid && !pkt_start
    |=> $stable(acc_r))
    else $error("unchecked element changed the sum");
  AST_OUT_RANGE: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_10]
    (state_r == MBCRC_IDLE) && byte_valid && !in_range && !chk_valid && !pkt_start
    |=> $stable(acc_r))
    else $error("byte outside range changed the sum");
  AST_TX_ORDER: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_09]
    crc_done |-> ({tx_hi, tx_lo} == crc_value))
    else $error("check bytes out of order");
  AST_CHK_ERR: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_12]
    chk_hi_take |=> chk_done && (chk_error == ({$past(chk_byte), $past(rx_lo_r)}
                                               != $past(crc_value_r))))
    else $error("check error flag wrong");
  AST_STEP_PLAIN: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_06]
    shifting && !pkt_start && !acc_r[0] |=> (acc_r == ($past(acc_r) >> 1)))
    else $error("plain shift step wrong");
  AST_CNT_ZERO: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_07]
    take_byte && !pkt_start |=> (shift_cnt_r == 4'h0))
    else $error("shift count not restarted");
  AST_READY_LOW: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_07]
    shifting |-> !byte_ready)
    else $error("ready raised during shifts");
  AST_TAKE_READY: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_03]
    take_byte |-> byte_ready)
    else $error("byte taken without ready");
  AST_SEED_KEEP: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_02]
    !rtu_mode && (state_r == MBCRC_IDLE) && !pkt_start |=> $stable(acc_r))
    else $error("sum moved outside rtu mode");
  AST_DONE_VALUE: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_08]
    finish_now
    |=> crc_done && (crc_value == $past(acc_nxt)))
    else $error("finished value not the accumulator");
  AST_DONE_IDLE: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_08]
    crc_done |-> (state_r == MBCRC_IDLE))
    else $error("done while still shifting");
  AST_LATE_DONE: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_08]
    shifting && range_done && rtu_mode && !pkt_start
    |-> ##[1:8] (crc_done || pkt_start))
    else $error("late range end never finished");
  AST_CRC_HOLD: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_01]
    !finish_now && !pkt_start |=> $stable(crc_value))
    else $error("check value changed between finishes");
  AST_CHK_LOW: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_09]
    (state_r == MBCRC_IDLE) && chk_valid && rtu_mode && !take_byte && !pkt_start
    |=> (state_r == MBCRC_CHK_HI) && (rx_lo_r == $past(chk_byte)))
    else $error("low check byte not held");
  AST_CHK_IDLE: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_12]
    chk_done |-> (state_r == MBCRC_IDLE))
    else $error("compare left engine busy");
  AST_ERR_HOLD: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_12]
    !chk_hi_take && !pkt_start |=> $stable(chk_error))
    else $error("error flag changed without compare");
  AST_PKT_CLEAR: assert property (@(posedge clk) disable iff (!resetn) // see [RULE_12]
    pkt_start |=> !chk_error && (crc_value == `MBCRC_SEED))
    else $error("packet start did not clear results");

  // ----------------------------------------------------------------------
  // Cover
  // ----------------------------------------------------------------------
  COV_LATE: cover property (@(posedge clk) disable iff (!resetn)
    shifting && range_done);
  COV_BYTE: cover property (@(posedge clk) disable iff (!resetn)
    take_byte ##9 take_byte);
  COV_DONE: cover property (@(posedge clk) disable iff (!resetn) crc_done);
  COV_ERR: cover property (@(posedge clk) disable iff (!resetn) chk_done && chk_error);
  COV_OK: cover property (@(posedge clk) disable iff (!resetn) chk_done && !chk_error);
endmodule // mbcrc_engine

// [design/mbcrc_step.sv]
// One conditional shift-and-xor step of the reflected register.
// Assumes the engine calls it once per clock.
`timescale 1ns/1ps
`include "mbcrc_cfg.svh"
module mbcrc_step (
  // Step carrier
  mbcrc_step_if.stage st
);
  import mbcrc_pkg::*;
  wire lsb_out = st.acc_in[0];
  wire [15:0] shifted = {1'b0, st.acc_in[15:1]};
  assign st.acc_out = lsb_out ? (shifted ^ `MBCRC_POLY) : shifted; // see [RULE_06]
endmodule // mbcrc_step

// [shared/mbcrc_cfg.svh]
// Constants of the check-code engine: polynomial, seed, widths, counts.
// Assumes inclusion by bare name; definitions only.
`ifndef MBCRC_CFG_SVH
`define MBCRC_CFG_SVH
// ----------------------------------------------------------------------
// Arithmetic
// ----------------------------------------------------------------------
`define MBCRC_POLY 16'ha001
`define MBCRC_SEED 16'hffff
`define MBCRC_SHIFTS 4'h8
// ----------------------------------------------------------------------
// Range and reset values
// ----------------------------------------------------------------------
`define MBCRC_POS_W 16
`define MBCRC_POS_RST 16'h0000
`define MBCRC_BYTE_RST 8'h00
`endif

// [shared/mbcrc_pkg.sv]
// Types shared by the check-code engine and its shift stage.
// Assumes the cfg header is on the include path.
`include "mbcrc_cfg.svh"
package mbcrc_pkg;
  typedef logic [15:0] mbcrc_word_t;
  typedef logic [7:0] mbcrc_byte_t;
  typedef logic [`MBCRC_POS_W-1:0] mbcrc_pos_t;
  typedef enum logic [1:0] {MBCRC_FRAME_RTU, MBCRC_FRAME_ASCII, MBCRC_FRAME_OTHER} mbcrc_frame_t;
  typedef enum {MBCRC_IDLE, MBCRC_SHIFT, MBCRC_CHK_LO, MBCRC_CHK_HI} mbcrc_state_t;
endpackage

// [shared/mbcrc_step_if.sv]
// Carrier between the engine and its one-bit shift stage.
// Assumes a single clock domain; purely combinational signals.
`timescale 1ns/1ps
interface mbcrc_step_if;
  import mbcrc_pkg::*;
  mbcrc_word_t acc_in;
  mbcrc_word_t acc_out;
  modport eng (output acc_in, input acc_out);
  modport stage (input acc_in, output acc_out);
endinterface

// [tb/mbcrc_framer.sv]
// Partner model: framer feeding frame bytes, range end and check bytes.
// Assumes one clock; its tasks are called from the bench top.
`timescale 1ns/1ps
module mbcrc_framer (
  // Clock and status
  input wire logic clk,
  input wire logic byte_ready,
  // Stream toward the engine
  output logic pkt_start,
  output logic byte_valid,
  output mbcrc_pkg::mbcrc_byte_t byte_data,
  output mbcrc_pkg::mbcrc_pos_t byte_pos,
  output logic byte_unchecked,
  output logic range_done,
  output logic chk_valid,
  output mbcrc_pkg::mbcrc_byte_t chk_byte
);
  import mbcrc_pkg::*;
  int stall_err = 0;
  initial begin
    {pkt_start, byte_valid, byte_unchecked, range_done, chk_valid} = '0;
    byte_data = '0;
    byte_pos = '0;
    chk_byte = '0;
  end
  // Start (0) or range end (1), one cycle
  task automatic strobe(input bit fin);
    @(posedge clk);
    if (fin) range_done <= 1'b1;
    else pkt_start <= 1'b1;
    @(posedge clk);
    range_done <= 1'b0;
    pkt_start <= 1'b0;
  endtask
  // Held until an edge samples byte_ready high or 40 edges pass; packet order is the caller's
  task automatic send_byte(input mbcrc_byte_t d, input mbcrc_pos_t p, input logic u);
    int i;
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_data <= d;
    byte_pos <= p;
    byte_unchecked <= u;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (byte_ready === 1'b1) break;
    end
    if (i == 40) stall_err++;
    byte_valid <= 1'b0;
    byte_data <= ~d;  // Released data never shows the old byte; byte_pos and byte_unchecked keep theirs
  endtask
  // Check value goes low byte first
  task automatic send_chk(input mbcrc_word_t w);
    @(posedge clk);
    chk_valid <= 1'b1;
    chk_byte <= w[7:0];
    @(posedge clk);
    chk_byte <= w[15:8];
    @(posedge clk);
    chk_valid <= 1'b0;
    chk_byte <= ~w[15:8];
  endtask
endmodule // mbcrc_framer

// [tb/tb_mbcrc_engine.sv]
// Bench for the check-code engine against an integer reference model.
// Assumes the shared package and the framer partner model are compiled.
`timescale 1ns/1ps
module tb_mbcrc_engine;
  import mbcrc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  mbcrc_frame_t frame_mode = MBCRC_FRAME_RTU;
  mbcrc_pos_t range_start = '0;
  mbcrc_pos_t range_end = '0;
  logic pkt_start, byte_valid, byte_unchecked, range_done, chk_valid, byte_ready;
  logic crc_done, chk_done, chk_error;
  mbcrc_byte_t byte_data, chk_byte, tx_lo, tx_hi;
  mbcrc_pos_t byte_pos;
  mbcrc_word_t crc_value;
  int fail_count = 0;
  int check_count = 0;
  integer seed = 32'hf1b8d983;
  always #2 clk = ~clk;
  mbcrc_engine mbcrc_engine_inst (.clk(clk), .resetn(resetn), .frame_mode(frame_mode),
    .range_start(range_start), .range_end(range_end), .pkt_start(pkt_start),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_pos(byte_pos),
    .byte_unchecked(byte_unchecked), .range_done(range_done), .byte_ready(byte_ready),
    .chk_valid(chk_valid), .chk_byte(chk_byte), .crc_value(crc_value), .crc_done(crc_done),
    .tx_lo(tx_lo), .tx_hi(tx_hi), .chk_done(chk_done), .chk_error(chk_error));
  mbcrc_framer mbcrc_framer_inst (.clk(clk), .byte_ready(byte_ready), .pkt_start(pkt_start),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_pos(byte_pos),
    .byte_unchecked(byte_unchecked), .range_done(range_done), .chk_valid(chk_valid),
    .chk_byte(chk_byte));
  // ----------------------------------------------------------------------
  // Reference model and helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] ref_crc(input mbcrc_byte_t q[$]);
    logic [15:0] c = 16'hffff;
    foreach (q[i]) begin
      c[7:0] = c[7:0] ^ q[i];
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t engine gave %h, model %h", $time, seen, exp);
    end
  endtask
  task automatic wait_flag(input bit chk);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if ((chk ? chk_done : crc_done) === 1'b1) break;
    end
    if (i == 40) check(16'h0, 16'h1);
  endtask
  task automatic finish_pkt(input logic [15:0] exp);
    mbcrc_framer_inst.strobe(1'b1);
    wait_flag(1'b0);
    check(crc_value, exp);
    check({tx_hi, tx_lo}, exp);
  endtask
  // Random packet, range s..e, some unchecked elements; bad flips a check bit
  task automatic run_pkt(input int n, input int s, input int e, input bit bad);
    mbcrc_byte_t q[$];
    mbcrc_byte_t d;
    logic u;
    logic [15:0] exp;
    @(posedge clk);
    range_start <= s[15:0];
    range_end <= e[15:0];
    mbcrc_framer_inst.strobe(1'b0);
    for (int k = 0; k < n; k++) begin
      d = $random(seed);
      u = ($random(seed) & 3) == 0;
      if (k >= s && k <= e && !u) q.push_back(d);
      mbcrc_framer_inst.send_byte(d, k[15:0], u);
    end
    exp = ref_crc(q);
    finish_pkt(exp);
    mbcrc_framer_inst.send_chk(exp ^ {15'h0, bad});
    wait_flag(1'b1);
    check({15'h0, chk_error}, {15'h0, bad});
  endtask
  task automatic conclude();
    fail_count += mbcrc_framer_inst.stall_err;
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    check(crc_value, 16'hffff);
    check({15'h0, byte_ready}, 16'h0);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    range_end <= 16'h0001;
    mbcrc_framer_inst.strobe(1'b0);
    mbcrc_framer_inst.send_byte(8'h02, 16'h0000, 1'b0);
    mbcrc_framer_inst.send_byte(8'h07, 16'h0001, 1'b0);
    finish_pkt(16'h1241);
    // Other framing modes leave the seed untouched
    for (int m = 1; m < 3; m++) begin
      @(posedge clk);
      frame_mode <= mbcrc_frame_t'(m);
      mbcrc_framer_inst.strobe(1'b0);
      mbcrc_framer_inst.send_byte(8'h5a, 16'h0000, 1'b0);
      @(posedge clk);
      frame_mode <= MBCRC_FRAME_RTU;
      finish_pkt(16'hffff);
    end
    for (int p = 0; p < 24; p++) run_pkt(4 + p % 6, p % 3, 3 + p % 6 - (p / 3) % 3, p[0]);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    check(crc_value, 16'hffff);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    run_pkt(6, 0, 5, 1'b0);
    conclude();
  end
  initial begin
    #80000;
    fail_count++;
    conclude();
  end
endmodule // tb_mbcrc_engine
